//--- src/line_tuning_defines.vh
`ifndef LINE_TUNING_DEFINES_VH
`define LINE_TUNING_DEFINES_VH

// Bus geometry
`define LT_ADDR_W           8
`define LT_DATA_W           32

// Printed register index and the byte address derived from it
`define LT_TUNING_INDEX     8'h12
`define LT_TUNING_ADDR      (`LT_TUNING_INDEX * 4)
`define LT_SOFT_CTRL_ADDR   8'h00
`define LT_STATUS_ADDR      8'h04

// Tuning register fields
`define LT_GAUGE_HI_BIT     7
`define LT_GAUGE_LO_BIT     6
`define LT_TX_HANDOVER_BIT  5
`define LT_RX_HANDOVER_BIT  4
`define LT_SLICE_HI_BIT     3
`define LT_SLICE_LO_BIT     2
`define LT_EQ_HI_BIT        1
`define LT_EQ_LO_BIT        0
`define LT_TUNING_RESET     8'h00

// Soft control register fields
`define LT_SOFT_TX_ON_BIT   0
`define LT_SOFT_RX_TERM_BIT 1
`define LT_SOFT_CTRL_RESET  2'h0

// Status register fields
`define LT_ST_TX_EN_BIT     0
`define LT_ST_RX_TERM_BIT   1
`define LT_ST_HOST_BIT      2
`define LT_ST_TX_PIN_BIT    3
`define LT_ST_RX_PIN_BIT    4

// Field codes
`define LT_GAUGE_MIXED      2'h0
`define LT_GAUGE_22         2'h1
`define LT_GAUGE_24         2'h2
`define LT_GAUGE_26         2'h3
`define LT_SLICE_DOWN       2'h1
`define LT_SLICE_UP         2'h2
`define LT_EQ_CUT_1DB       2'h1
`define LT_EQ_CUT_3DB       2'h2

// Bus responses
`define LT_RESP_OKAY        2'h0
`define LT_RESP_SLVERR      2'h2

`endif

//--- src/pin_sync.v
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 3
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            // Only the second stage is visible outside
            always @(posedge aclk) begin
                if (!aresetn) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= pin_in[i];
                    sync_q <= meta_q;
                end
            end
            assign pin_sync_out[i] = sync_q;
        end
    endgenerate

endmodule

//--- src/line_tuning_ctrl.v
// What this block does
// - Eight-bit read/write tuning register at index 0x12, resets to zero.
// - Wire gauge bits 7:6: 00 mixed 22/24, 01 22, 10 24, 11 26 gauge.
// - Host mode, bit 5 set: transmit on/off follows the hardware pin.
// - Host mode, bit 4 set: receive termination follows its select pin.
// - Slicer bits 3:2: 00/11 normal, 01 lower 5%, 10 raise 5%.
// - Equalizer bits 1:0: 00/11 normal, 01 cut 1 dB, 10 cut 3 dB.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "line_tuning_defines.vh"
module line_tuning_ctrl (
    input  wire                  aclk,
    input  wire                  aresetn,
    input  wire [`LT_ADDR_W-1:0] s_axi_awaddr,
    input  wire [2:0]            s_axi_awprot,
    input  wire                  s_axi_awvalid,
    output reg                   s_axi_awready,
    input  wire [`LT_DATA_W-1:0] s_axi_wdata,
    input  wire [3:0]            s_axi_wstrb,
    input  wire                  s_axi_wvalid,
    output reg                   s_axi_wready,
    output reg  [1:0]            s_axi_bresp,
    output reg                   s_axi_bvalid,
    input  wire                  s_axi_bready,
    input  wire [`LT_ADDR_W-1:0] s_axi_araddr,
    input  wire [2:0]            s_axi_arprot,
    input  wire                  s_axi_arvalid,
    output reg                   s_axi_arready,
    output reg  [`LT_DATA_W-1:0] s_axi_rdata,
    output reg  [1:0]            s_axi_rresp,
    output reg                   s_axi_rvalid,
    input  wire                  s_axi_rready,
    input  wire                  host_mode_pin,
    input  wire                  tx_enable_pin,
    input  wire                  rx_termination_select_pin,
    output reg                   gauge_mixed_q,
    output reg                   gauge_22_q,
    output reg                   gauge_24_q,
    output reg                   gauge_26_q,
    output reg                   slice_lower_q,
    output reg                   slice_raise_q,
    output reg                   eq_cut_1db_q,
    output reg                   eq_cut_3db_q,
    output reg                   tx_enable_q,
    output reg                   rx_termination_q
);

    // Pins come from outside the clock domain
    wire [2:0] pins_sync;
    wire       host_mode_s;
    wire       tx_pin_s;
    wire       rx_pin_s;

    pin_sync #(
        .WIDTH        (3)
    ) u_pin_sync (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .pin_in       ({rx_termination_select_pin, tx_enable_pin,
                        host_mode_pin}),
        .pin_sync_out (pins_sync)
    );

    assign host_mode_s = pins_sync[0];
    assign tx_pin_s    = pins_sync[1];
    assign rx_pin_s    = pins_sync[2];

    // Register state
    reg  [7:0] tuning_q;
    reg  [1:0] soft_ctrl_q;

    wire [1:0] gauge_sel;
    wire [1:0] slice_sel;
    wire [1:0] eq_sel;
    wire       tx_handover;
    wire       rx_handover;

    assign gauge_sel   = {tuning_q[`LT_GAUGE_HI_BIT],
                          tuning_q[`LT_GAUGE_LO_BIT]};
    assign slice_sel   = {tuning_q[`LT_SLICE_HI_BIT],
                          tuning_q[`LT_SLICE_LO_BIT]};
    assign eq_sel      = {tuning_q[`LT_EQ_HI_BIT],
                          tuning_q[`LT_EQ_LO_BIT]};
    assign tx_handover = tuning_q[`LT_TX_HANDOVER_BIT];
    assign rx_handover = tuning_q[`LT_RX_HANDOVER_BIT];

    // Write channel state
    reg                  aw_full_q;
    reg                  w_full_q;
    reg [`LT_ADDR_W-1:0] awaddr_q;
    reg [7:0]            wdata_q;
    reg [3:0]            wstrb_q;

    wire aw_take;
    wire w_take;
    wire wr_exec;
    wire b_done;
    wire ar_take;
    wire r_done;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take  = s_axi_wvalid && s_axi_wready;
    assign wr_exec = aw_full_q && w_full_q && !s_axi_bvalid;
    assign b_done  = s_axi_bvalid && s_axi_bready;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign r_done  = s_axi_rvalid && s_axi_rready;

    wire wr_tuning;
    wire wr_soft;
    wire wr_status;
    wire wr_mapped;

    // Word-aligned decode; the low two address bits are ignored
    localparam [31:0]           TUNING_BYTE = `LT_TUNING_ADDR;
    localparam [`LT_ADDR_W-1:0] SOFT_BYTE   = `LT_SOFT_CTRL_ADDR;
    localparam [`LT_ADDR_W-1:0] STATUS_BYTE = `LT_STATUS_ADDR;
    localparam [`LT_ADDR_W-3:0] TUNING_WORD = TUNING_BYTE[`LT_ADDR_W-1:2];
    localparam [`LT_ADDR_W-3:0] SOFT_WORD   = SOFT_BYTE[`LT_ADDR_W-1:2];
    localparam [`LT_ADDR_W-3:0] STATUS_WORD = STATUS_BYTE[`LT_ADDR_W-1:2];
    assign wr_tuning = (awaddr_q[`LT_ADDR_W-1:2] == TUNING_WORD);
    assign wr_soft   = (awaddr_q[`LT_ADDR_W-1:2] == SOFT_WORD);
    assign wr_status = (awaddr_q[`LT_ADDR_W-1:2] == STATUS_WORD);
    assign wr_mapped = wr_tuning || wr_soft || wr_status;

    // Address and data may arrive in either order; each is held until both
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            awaddr_q      <= {`LT_ADDR_W{1'b0}};
            wdata_q       <= 8'h00;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `LT_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_full_q     <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_full_q     <= 1'b1;
                wdata_q      <= s_axi_wdata[7:0];
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_exec) begin
                aw_full_q    <= 1'b0;
                w_full_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? `LT_RESP_OKAY
                                          : `LT_RESP_SLVERR;
            end
            if (b_done) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Registers; only lane 0 carries data since fields are eight bits
    always @(posedge aclk) begin
        if (!aresetn) begin
            tuning_q    <= `LT_TUNING_RESET;
            soft_ctrl_q <= `LT_SOFT_CTRL_RESET;
        end else if (wr_exec && wstrb_q[0]) begin
            if (wr_tuning)
                tuning_q <= wdata_q;
            if (wr_soft)
                soft_ctrl_q <= wdata_q[1:0];
        end
    end

    // Read path
    reg  [`LT_DATA_W-1:0] rd_word;
    reg                   rd_hit;
    wire [4:0]            status_bits;

    assign status_bits = {rx_pin_s, tx_pin_s, host_mode_s,
                          rx_termination_q, tx_enable_q};

    always @* begin
        rd_word = {`LT_DATA_W{1'b0}};
        rd_hit  = 1'b1;
        case (s_axi_araddr[`LT_ADDR_W-1:2])
            TUNING_WORD: begin
                rd_word[7:0] = tuning_q;
            end
            SOFT_WORD: begin
                rd_word[1:0] = soft_ctrl_q;
            end
            STATUS_WORD: begin
                rd_word[4:0] = status_bits;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= {`LT_DATA_W{1'b0}};
            s_axi_rresp   <= `LT_RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_hit ? `LT_RESP_OKAY
                                        : `LT_RESP_SLVERR;
            end else if (r_done) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Decoded line settings, one flop per output
    reg g_mixed_d;
    reg g_22_d;
    reg g_24_d;
    reg g_26_d;
    reg sl_lower_d;
    reg sl_raise_d;
    reg eq_1_d;
    reg eq_3_d;
    reg tx_en_d;
    reg rx_term_d;

    always @* begin
        g_mixed_d = 1'b0;
        g_22_d    = 1'b0;
        g_24_d    = 1'b0;
        g_26_d    = 1'b0;
        case (gauge_sel)
            `LT_GAUGE_MIXED: g_mixed_d = 1'b1;
            `LT_GAUGE_22:    g_22_d    = 1'b1;
            `LT_GAUGE_24:    g_24_d    = 1'b1;
            default:         g_26_d    = 1'b1;
        endcase
    end

    always @* begin
        sl_lower_d = 1'b0;
        sl_raise_d = 1'b0;
        // Codes 00 and 11 both leave the threshold nominal
        case (slice_sel)
            `LT_SLICE_DOWN: sl_lower_d = 1'b1;
            `LT_SLICE_UP:   sl_raise_d = 1'b1;
            default: begin
                sl_lower_d = 1'b0;
                sl_raise_d = 1'b0;
            end
        endcase
    end

    always @* begin
        eq_1_d = 1'b0;
        eq_3_d = 1'b0;
        case (eq_sel)
            `LT_EQ_CUT_1DB: eq_1_d = 1'b1;
            `LT_EQ_CUT_3DB: eq_3_d = 1'b1;
            default: begin
                eq_1_d = 1'b0;
                eq_3_d = 1'b0;
            end
        endcase
    end

    // Outside host mode the pins always rule; in host mode the handover
    // bits choose between pin and soft control
    always @* begin
        if (!host_mode_s || tx_handover)
            tx_en_d = tx_pin_s;
        else
            tx_en_d = soft_ctrl_q[`LT_SOFT_TX_ON_BIT];
        if (!host_mode_s || rx_handover)
            rx_term_d = rx_pin_s;
        else
            rx_term_d = soft_ctrl_q[`LT_SOFT_RX_TERM_BIT];
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            gauge_mixed_q    <= 1'b1;
            gauge_22_q       <= 1'b0;
            gauge_24_q       <= 1'b0;
            gauge_26_q       <= 1'b0;
            slice_lower_q    <= 1'b0;
            slice_raise_q    <= 1'b0;
            eq_cut_1db_q     <= 1'b0;
            eq_cut_3db_q     <= 1'b0;
            tx_enable_q      <= 1'b0;
            rx_termination_q <= 1'b0;
        end else begin
            gauge_mixed_q    <= g_mixed_d;
            gauge_22_q       <= g_22_d;
            gauge_24_q       <= g_24_d;
            gauge_26_q       <= g_26_d;
            slice_lower_q    <= sl_lower_d;
            slice_raise_q    <= sl_raise_d;
            eq_cut_1db_q     <= eq_1_d;
            eq_cut_3db_q     <= eq_3_d;
            tx_enable_q      <= tx_en_d;
            rx_termination_q <= rx_term_d;
        end
    end

    // Protection bits carry no meaning for this block
    wire unused_prot;
    assign unused_prot = ^{s_axi_awprot, s_axi_arprot,
                           s_axi_awaddr[1:0], s_axi_araddr[1:0],
                           wstrb_q[3:1]};

endmodule

//--- sim/tuning_checker.sv
`timescale 1ns/1ps
module tuning_checker (
    input logic        aclk,
    input logic        aresetn,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [7:0]  s_axi_araddr,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic        gauge_mixed_q,
    input logic        gauge_22_q,
    input logic        gauge_24_q,
    input logic        gauge_26_q,
    input logic        slice_lower_q,
    input logic        slice_raise_q,
    input logic        eq_cut_1db_q,
    input logic        eq_cut_3db_q
);
    logic tun_q;
    logic ar_go;
    assign ar_go = s_axi_arvalid && s_axi_arready;
    // Remembers whether the read in flight targets the tuning word
    always_ff @(posedge aclk) begin
        if (!aresetn)
            tun_q <= 1'b0;
        else if (ar_go)
            tun_q <= s_axi_araddr[7:2] == 6'h12;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    gauge_dec_a: assert property (s_axi_rvalid && tun_q |->
        {gauge_26_q, gauge_24_q, gauge_22_q, gauge_mixed_q}
        == 4'h1 << s_axi_rdata[7:6]) else $error("gauge decode");
    slice_dec_a: assert property (s_axi_rvalid && tun_q |->
        {slice_raise_q, slice_lower_q} == (^s_axi_rdata[3:2] ?
        s_axi_rdata[3:2] : 2'h0)) else $error("slicer decode");
    eq_dec_a: assert property (s_axi_rvalid && tun_q |->
        {eq_cut_3db_q, eq_cut_1db_q} == (^s_axi_rdata[1:0] ?
        s_axi_rdata[1:0] : 2'h0)) else $error("equalizer decode");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("late write response");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    rd_resp_a: assert property (ar_go |=> s_axi_rvalid)
        else $error("late read data");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    rd_unmap_a: assert property (ar_go && s_axi_araddr[7:2] != 6'h12
        && s_axi_araddr[7:3] != 5'h0 |=> s_axi_rresp == 2'h2
        && s_axi_rdata == 32'h0) else $error("unmapped read");
endmodule

bind line_tuning_ctrl tuning_checker tuning_checker_i (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .gauge_mixed_q (gauge_mixed_q),
    .gauge_22_q    (gauge_22_q),
    .gauge_24_q    (gauge_24_q),
    .gauge_26_q    (gauge_26_q),
    .slice_lower_q (slice_lower_q),
    .slice_raise_q (slice_raise_q),
    .eq_cut_1db_q  (eq_cut_1db_q),
    .eq_cut_3db_q  (eq_cut_3db_q)
);

//--- sim/tb_line_tuning_ctrl.sv
`timescale 1ns/1ps
module tb_line_tuning_ctrl;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, host_mode_pin;
    logic tx_enable_pin, rx_termination_select_pin, tx_enable_q;
    logic rx_termination_q, gauge_mixed_q, gauge_22_q, gauge_24_q;
    logic gauge_26_q, slice_lower_q, slice_raise_q, eq_cut_1db_q;
    logic eq_cut_3db_q;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, tune_m;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [3:0]  s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, soft_m, rs;
    int          bad_count, total_checks;

    line_tuning_ctrl line_tuning_ctrl_i (.*);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Every bus wait is bounded so a dead slave ends the run
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 40) begin
            bad_count++;
            tally_and_finish;
        end
    endtask

    // Response ready rises at the first edge and drops once the answer is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            tick(n);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            s_axi_bready <= !(s_axi_bvalid && s_axi_bready);
        end while (!(s_axi_bvalid && s_axi_bready));
        rs = s_axi_bresp;
    endtask

    task automatic rdt(input logic [7:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            tick(n);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            s_axi_rready <= !(s_axi_rvalid && s_axi_rready);
        end while (!(s_axi_rvalid && s_axi_rready));
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask

    task automatic chk_out;
        logic [1:0] g, s, e;
        logic       tx, rx, h;
        logic [1:0] p;
        g = tune_m[7:6];
        s = tune_m[3:2];
        e = tune_m[1:0];
        h = host_mode_pin;
        p = {rx_termination_select_pin, tx_enable_pin};
        tx = (!h || tune_m[5]) ? tx_enable_pin : soft_m[0];
        rx = (!h || tune_m[4]) ? rx_termination_select_pin : soft_m[1];
        chk({gauge_mixed_q, gauge_22_q, gauge_24_q, gauge_26_q},
            {g == 2'h0, g == 2'h1, g == 2'h2, g == 2'h3});
        chk({slice_lower_q, slice_raise_q}, {s == 2'h1, s == 2'h2});
        chk({eq_cut_1db_q, eq_cut_3db_q}, {e == 2'h1, e == 2'h2});
        chk({tx_enable_q, rx_termination_q}, {tx, rx});
        rdt(8'h04);
        chk(rd, {27'h0, p, h, rx, tx});
    endtask

    initial begin
        logic [31:0] w;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {host_mode_pin, tx_enable_pin, rx_termination_select_pin} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_awprot, s_axi_arprot} = 6'h0;
        s_axi_wstrb = 4'hf;
        {bad_count, total_checks} = 64'h0;
        {tune_m, soft_m} = 10'h0;
        void'($urandom(32'h2b1f6bf8));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdt(8'h48);
        chk(rd, 32'h0);
        chk_out;
        for (int i = 0; i < 24; i++) begin
            w = $urandom;
            // First passes walk every code of the gauge, slicer and equalizer fields
            if (i < 4) w[7:0] = {i[1:0], w[5:4], i[1:0], i[1:0]};
            wr(8'h48, w);
            chk(rs, 2'h0);
            tune_m = w[7:0];
            w = $urandom;
            wr(8'h00, w);
            soft_m = w[1:0];
            {host_mode_pin, tx_enable_pin, rx_termination_select_pin} <=
                3'($urandom);
            repeat (4) @(posedge aclk);
            rdt(8'h48);
            chk(rd, {24'h0, tune_m});
            chk_out;
        end
        wr(8'h10, 32'hff);
        chk(rs, 2'h2);
        wr(8'h04, 32'hff);
        chk(rs, 2'h0);
        rdt(8'h10);
        chk({rs, rd[29:0]}, 32'h80000000);
        rdt(8'h48);
        chk(rd, {24'h0, tune_m});
        // Lane 0 disabled: the write is answered but changes nothing
        s_axi_wstrb <= 4'he;
        wr(8'h48, ~{24'h0, tune_m});
        chk(rs, 2'h0);
        s_axi_wstrb <= 4'hf;
        rdt(8'h48);
        chk(rd, {24'h0, tune_m});
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        {tune_m, soft_m} = 10'h0;
        rdt(8'h48);
        chk(rd, {24'h0, tune_m});
        repeat (4) @(posedge aclk);
        chk_out;
        tally_and_finish;
    end
endmodule
